/* File: pkg/vld_pkg.sv */
package vld_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [6:0] DEV_ADDR = 7'h6a;
  localparam logic [7:0] ADDR_CH1_GAIN = 8'h05;
  localparam logic [7:0] ADDR_CH4_GAIN = 8'h08;
  localparam logic [7:0] ADDR_LOAD_CTRL = 8'h09;
  localparam logic [7:0] ADDR_THR_CH12 = 8'h0a;
  localparam logic [7:0] ADDR_THR_CH34 = 8'h0b;
  localparam logic [7:0] ADDR_REPORT_CH12 = 8'h0c;
  localparam logic [7:0] ADDR_REPORT_CH34 = 8'h0d;
  localparam logic [7:0] GAIN_RESET = 8'hcf;
  localparam logic [7:0] GAIN_MUTE_BELOW = 8'h07;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'he3;
  localparam logic [7:0] THR_RESET = 8'h11;
  localparam int CANCEL_BIT = 7;
  localparam int RAMP_DBL_BIT = 6;
  localparam int SETTLE_DBL_BIT = 5;
  localparam int LINE_EN_BIT = 1;
  localparam int SKIP_BIT = 0;
  localparam int FLG_GND = 3;
  localparam int FLG_SUP = 2;
  localparam int FLG_OPEN = 1;
  localparam int FLG_SHORT = 0;
  localparam logic [1:0] STATE_HIZ = 2'h1;
  localparam logic [1:0] STATE_LOAD_CHECK = 2'h3;
  localparam int RAMP_TIME_NS = 100000;
  localparam int SETTLE_TIME_NS = 50000;
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] RAMP_CYC =
    TIMER_W'((RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SETTLE_CYC =
    TIMER_W'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    I2_IDLE, I2_ADDR, I2_ADDR_ACK, I2_WR, I2_WR_ACK, I2_RD, I2_RD_ACK
  } vld_i2c_state_t;
  typedef enum logic [1:0] {DG_IDLE, DG_RAMP, DG_SETTLE, DG_SAMPLE} vld_diag_state_t;
endpackage

/* File: src/vld_load_check.sv */
`timescale 1ns/1ps
module vld_load_check (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] start_req_in,
  input wire logic cancel_in,
  input wire logic ramp_dbl_in,
  input wire logic settle_dbl_in,
  input wire logic line_en_in,
  input wire logic [15:0] thr_in,
  input wire logic [3:0] gnd_short_in,
  input wire logic [3:0] sup_short_in,
  input wire logic [3:0] open_in,
  input wire logic [3:0] line_in,
  input wire logic [15:0] res_in,
  output logic [15:0] flags_out,
  output logic [3:0] line_found_out,
  output logic [3:0] run_mask_out,
  output logic ramp_active_out,
  output logic settle_active_out,
  output logic cancel_done_out
);
  import vld_pkg::*;
  vld_diag_state_t state, next_state;
  logic [TIMER_W-1:0] timer, next_timer, ramp_lim, settle_lim;
  logic [3:0] mask, next_mask, pend, next_pend, line, next_line;
  logic [15:0] flags, next_flags, sample, keep;
  logic done, next_done;

  assign ramp_lim = ramp_dbl_in ? TIMER_W'(RAMP_CYC * 2) : RAMP_CYC;
  assign settle_lim = settle_dbl_in ? TIMER_W'(SETTLE_CYC * 2) : SETTLE_CYC;

  // Channel i maps to nibble 3-i: ch1 high nibble of the flag word
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      logic is_line;
      assign is_line = line_en_in & line_in[i];
      assign sample[15-4*i] = gnd_short_in[i];
      assign sample[14-4*i] = sup_short_in[i];
      // A line amplifier input looks open; don't call it an open load
      assign sample[13-4*i] = open_in[i] & ~is_line;
      assign sample[12-4*i] = res_in[15-4*i -: 4] <= thr_in[15-4*i -: 4];
      assign keep[15-4*i -: 4] = {4{~mask[i]}};
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_mask = mask;
    next_pend = pend | start_req_in;
    next_flags = flags;
    next_line = line;
    next_done = 1'b0;
    if (cancel_in) begin
      next_state = DG_IDLE;
      next_timer = '0;
      next_mask = '0;
      next_pend = '0;
      next_done = 1'b1;
    end else begin
      case (state)
        DG_IDLE: begin
          if (next_pend != 4'h0) begin
            next_mask = next_pend;
            next_pend = '0;
            next_state = DG_RAMP;
            next_timer = ramp_lim - 1'b1;
          end
        end
        DG_RAMP: begin
          if (timer == '0) begin
            next_state = DG_SETTLE;
            next_timer = settle_lim - 1'b1;
          end else begin
            next_timer = timer - 1'b1;
          end
        end
        DG_SETTLE: begin
          if (timer == '0) begin
            next_state = DG_SAMPLE;
          end else begin
            next_timer = timer - 1'b1;
          end
        end
        DG_SAMPLE: begin
          next_flags = (flags & keep) | (sample & ~keep);
          next_line = (line & ~mask) | (line_in & mask & {4{line_en_in}});
          next_mask = '0;
          next_state = DG_IDLE;
        end
        default: next_state = DG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= DG_IDLE;
      timer <= '0;
      mask <= '0;
      pend <= '0;
      flags <= '0;
      line <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      mask <= next_mask;
      pend <= next_pend;
      flags <= next_flags;
      line <= next_line;
      done <= next_done;
    end
  end

  assign flags_out = flags;
  assign line_found_out = line;
  assign run_mask_out = mask;
  assign ramp_active_out = state == DG_RAMP;
  assign settle_active_out = state == DG_SETTLE;
  assign cancel_done_out = done;
endmodule

/* File: src/vld_volume_diag_regs.sv */
`timescale 1ns/1ps
module vld_volume_diag_regs (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic [7:0] chan_state_in,
  input wire logic [3:0] chan_fault_in,
  input wire logic [3:0] meas_gnd_short_in,
  input wire logic [3:0] meas_sup_short_in,
  input wire logic [3:0] meas_open_in,
  input wire logic [3:0] meas_line_in,
  input wire logic [15:0] meas_res_in,
  output logic [7:0] ch1_gain_out,
  output logic [7:0] ch2_gain_out,
  output logic [7:0] ch3_gain_out,
  output logic [7:0] ch4_gain_out,
  output logic [3:0] mute_out,
  output logic [3:0] load_check_mask_out,
  output logic ramp_active_out,
  output logic settle_active_out,
  output logic line_out_check_en_out,
  output logic [3:0] line_found_out
);
  import vld_pkg::*;

  // Pin synchronisers: index 0 is scl, 1 is sda
  logic [1:0] s1, s2, s3, pin_f, next_pin_f, pin_d;
  logic scl_rise, scl_fall, i2_start, i2_stop;

  // Register state
  logic [7:0] gain [4];
  logic [7:0] next_gain [4];
  logic [7:0] ctrl, next_ctrl, thr12, next_thr12, thr34, next_thr34;
  logic [15:0] flags;
  logic cancel_done;

  // Serial port state
  vld_i2c_state_t st, next_st;
  logic [2:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, ptr, next_ptr, rd_byte;
  logic rw, next_rw, first, next_first, ack_on, next_ack_on;
  logic drv_low, next_drv_low;
  logic wr_fire;
  logic [7:0] wr_byte;

  // Channel trigger state
  logic [7:0] state_d;
  logic [3:0] fault_d, start_req;

  // Unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a >= ADDR_CH1_GAIN && a <= ADDR_CH4_GAIN) begin
      d = gain[2'(a - ADDR_CH1_GAIN)];
    end else begin
      case (a)
        ADDR_LOAD_CTRL: d = ctrl & CTRL_RW_MASK;
        ADDR_THR_CH12: d = thr12;
        ADDR_THR_CH34: d = thr34;
        ADDR_REPORT_CH12: d = flags[15:8];
        ADDR_REPORT_CH34: d = flags[7:0];
        default: d = 8'h00;
      endcase
    end
    return d;
  endfunction

  // Three stages; filtered level moves only when stages two and three agree
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      next_pin_f[k] = (s2[k] == s3[k]) ? s3[k] : pin_f[k];
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      pin_f <= 2'h3;
      pin_d <= 2'h3;
    end else begin
      s1 <= {sda_in, scl_in};
      s2 <= s1;
      s3 <= s2;
      pin_f <= next_pin_f;
      pin_d <= pin_f;
    end
  end

  assign scl_rise = pin_f[0] & ~pin_d[0];
  assign scl_fall = ~pin_f[0] & pin_d[0];
  assign i2_start = pin_f[0] & pin_d[0] & pin_d[1] & ~pin_f[1];
  assign i2_stop = pin_f[0] & pin_d[0] & ~pin_d[1] & pin_f[1];
  assign rd_byte = reg_read(ptr);

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_rw = rw;
    next_first = first;
    next_ack_on = ack_on;
    next_drv_low = drv_low;
    wr_fire = 1'b0;
    wr_byte = {sh[6:0], pin_f[1]};
    if (i2_start) begin
      next_st = I2_ADDR;
      next_cnt = '0;
      next_first = 1'b1;
      next_ack_on = 1'b0;
      next_drv_low = 1'b0;
    end else if (i2_stop) begin
      next_st = I2_IDLE;
      next_drv_low = 1'b0;
    end else if (scl_rise) begin
      case (st)
        I2_ADDR, I2_WR: begin
          next_sh = wr_byte;
          next_cnt = cnt + 1'b1;
          if (cnt == 3'h7) begin
            if (st == I2_WR) begin
              next_st = I2_WR_ACK;
              if (first) begin
                next_ptr = wr_byte;
                next_first = 1'b0;
              end else begin
                wr_fire = 1'b1;
                next_ptr = ptr + 1'b1;
              end
            end else if (wr_byte[7:1] == DEV_ADDR) begin
              next_st = I2_ADDR_ACK;
              next_rw = wr_byte[0];
            end else begin
              next_st = I2_IDLE;
            end
          end
        end
        I2_RD: begin
          next_cnt = cnt + 1'b1;
          if (cnt == 3'h7) begin
            next_st = I2_RD_ACK;
            next_ptr = ptr + 1'b1;
          end
        end
        I2_RD_ACK: begin
          // Master acknowledge keeps the read going; no-ack ends it
          if (!pin_f[1]) begin
            next_st = I2_RD;
            next_cnt = '0;
            next_sh = rd_byte;
          end else begin
            next_st = I2_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st)
        I2_ADDR_ACK, I2_WR_ACK: begin
          if (!ack_on) begin
            next_ack_on = 1'b1;
            next_drv_low = 1'b1;
          end else begin
            next_ack_on = 1'b0;
            next_drv_low = 1'b0;
            next_cnt = '0;
            if (st == I2_ADDR_ACK && rw) begin
              next_st = I2_RD;
              next_sh = rd_byte;
              next_drv_low = ~rd_byte[7];
            end else begin
              next_st = I2_WR;
            end
          end
        end
        I2_RD: next_drv_low = ~sh[3'h7 - cnt];
        I2_RD_ACK: next_drv_low = 1'b0;
        default: next_drv_low = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= I2_IDLE;
      cnt <= '0;
      sh <= '0;
      ptr <= '0;
      rw <= 1'b0;
      first <= 1'b0;
      ack_on <= 1'b0;
      drv_low <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      rw <= next_rw;
      first <= next_first;
      ack_on <= next_ack_on;
      drv_low <= next_drv_low;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~drv_low;

  // Register writes; report registers are read-only and absorb writes
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      next_gain[k] = gain[k];
    end
    next_ctrl = ctrl;
    next_thr12 = thr12;
    next_thr34 = thr34;
    if (cancel_done) begin
      next_ctrl[CANCEL_BIT] = 1'b0;
    end
    // Placed after the clear so a fresh cancel in that cycle survives
    if (wr_fire) begin
      if (ptr >= ADDR_CH1_GAIN && ptr <= ADDR_CH4_GAIN) begin
        next_gain[2'(ptr - ADDR_CH1_GAIN)] = wr_byte;
      end
      case (ptr)
        ADDR_LOAD_CTRL: next_ctrl = wr_byte & CTRL_RW_MASK;
        ADDR_THR_CH12: next_thr12 = wr_byte;
        ADDR_THR_CH34: next_thr34 = wr_byte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int k = 0; k < 4; k++) begin
        gain[k] <= GAIN_RESET;
      end
      ctrl <= CTRL_RESET;
      thr12 <= THR_RESET;
      thr34 <= THR_RESET;
    end else begin
      for (int k = 0; k < 4; k++) begin
        gain[k] <= next_gain[k];
      end
      ctrl <= next_ctrl;
      thr12 <= next_thr12;
      thr34 <= next_thr34;
    end
  end

  assign ch1_gain_out = gain[0];
  assign ch2_gain_out = gain[1];
  assign ch3_gain_out = gain[2];
  assign ch4_gain_out = gain[3];
  assign line_out_check_en_out = ctrl[LINE_EN_BIT];

  // Trigger detection; ch1 state sits in the top two bits
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_trig
      logic [1:0] now_st, old_st;
      logic manual, leave_hiz, fault_rise;
      assign now_st = chan_state_in[7-2*c -: 2];
      assign old_st = state_d[7-2*c -: 2];
      assign manual = now_st == STATE_LOAD_CHECK && old_st != STATE_LOAD_CHECK;
      assign leave_hiz = old_st == STATE_HIZ && now_st != STATE_HIZ;
      assign fault_rise = chan_fault_in[c] & ~fault_d[c];
      assign start_req[c] = manual | (~ctrl[SKIP_BIT] & (leave_hiz | fault_rise));
      assign mute_out[c] = gain[c] < GAIN_MUTE_BELOW;
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_d <= {4{STATE_HIZ}};
      fault_d <= '0;
    end else begin
      state_d <= chan_state_in;
      fault_d <= chan_fault_in;
    end
  end

  vld_load_check u_check (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .start_req_in(start_req),
    .cancel_in(ctrl[CANCEL_BIT]),
    .ramp_dbl_in(ctrl[RAMP_DBL_BIT]),
    .settle_dbl_in(ctrl[SETTLE_DBL_BIT]),
    .line_en_in(ctrl[LINE_EN_BIT]),
    .thr_in({thr12, thr34}),
    .gnd_short_in(meas_gnd_short_in),
    .sup_short_in(meas_sup_short_in),
    .open_in(meas_open_in),
    .line_in(meas_line_in),
    .res_in(meas_res_in),
    .flags_out(flags),
    .line_found_out(line_found_out),
    .run_mask_out(load_check_mask_out),
    .ramp_active_out(ramp_active_out),
    .settle_active_out(settle_active_out),
    .cancel_done_out(cancel_done)
  );
endmodule

/* File: testbench/vld_i2c_host.sv */
`timescale 1ns/1ps
module vld_i2c_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  import vld_pkg::*;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Ten clocks per quarter bit, well above the device's input filter delay
  task automatic hold();
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    hold();
    scl_out = 1'b1;
    hold();
    sda_low_out = 1'b1;
    hold();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    hold();
    sda_low_out = 1'b1;
    hold();
    scl_out = 1'b1;
    hold();
    sda_low_out = 1'b0;
    hold();
  endtask
  task automatic bit_io(input logic b, output logic got);
    hold();
    sda_low_out = !b;
    hold();
    scl_out = 1'b1;
    hold();
    got = sda_in;
    hold();
    scl_out = 1'b0;
  endtask
  // Released ninth bit: reads the slave ack on writes, sends nack on reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic n0;
    logic n1;
    logic n2;
    start();
    byte_io({DEV_ADDR, 1'b0}, rx, n0);
    byte_io(a, rx, n1);
    byte_io(d, rx, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic n0;
    logic n1;
    logic n2;
    logic n3;
    start();
    byte_io({DEV_ADDR, 1'b0}, rx, n0);
    byte_io(a, rx, n1);
    start();
    byte_io({DEV_ADDR, 1'b1}, rx, n2);
    byte_io(8'hff, d, n3);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule

/* File: testbench/vld_volume_diag_regs_checker.sv */
`timescale 1ns/1ps
module vld_volume_diag_regs_checker (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] chan_state_in,
  input wire logic [7:0] ch1_gain_out,
  input wire logic [7:0] ch2_gain_out,
  input wire logic [7:0] ch3_gain_out,
  input wire logic [7:0] ch4_gain_out,
  input wire logic [3:0] mute_out,
  input wire logic [3:0] load_check_mask_out,
  input wire logic ramp_active_out,
  input wire logic settle_active_out,
  input wire logic line_out_check_en_out,
  input wire logic [3:0] line_found_out
);
  logic [11:0] ramp_cnt;
  logic [11:0] settle_cnt;
  logic [11:0] next_ramp_cnt;
  logic [11:0] next_settle_cnt;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Doubling bits are not at the ports, so either length is accepted
  always_comb begin
    next_ramp_cnt = ramp_active_out ? ramp_cnt + 12'h001 : 12'h000;
    next_settle_cnt = settle_active_out ? settle_cnt + 12'h001 : 12'h000;
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ramp_cnt <= 12'h000;
      settle_cnt <= 12'h000;
    end else begin
      ramp_cnt <= next_ramp_cnt;
      settle_cnt <= next_settle_cnt;
    end
  end
  sequence s_ramp_done;
    $fell(ramp_active_out) && settle_active_out;
  endsequence
  sequence s_settle_done;
    $fell(settle_active_out) && !ramp_active_out && load_check_mask_out != 4'h0;
  endsequence
  a_ramp_len: assert property (s_ramp_done |-> ramp_cnt == 12'h3e8 || ramp_cnt == 12'h7d0)
    else $error("ramp phase length wrong");
  a_settle_len: assert property (s_settle_done |->
    settle_cnt == 12'h1f4 || settle_cnt == 12'h3e8)
    else $error("settle phase length wrong");
  a_sample_end: assert property (s_settle_done |-> ##1 load_check_mask_out == 4'h0)
    else $error("run did not end after sample cycle");
  a_run_start: assert property ($rose(load_check_mask_out != 4'h0) |-> ramp_active_out)
    else $error("run began without ramp");
  a_idle_quiet: assert property (load_check_mask_out == 4'h0 |->
    !ramp_active_out && !settle_active_out)
    else $error("phase active without channels");
  a_phase_excl: assert property (!(ramp_active_out && settle_active_out))
    else $error("ramp and settle together");
  a_mute_decode: assert property (mute_out == {
    ch4_gain_out < 8'h07, ch3_gain_out < 8'h07, ch2_gain_out < 8'h07, ch1_gain_out < 8'h07})
    else $error("mute does not follow gain codes");
  a_gain_reset: assert property ($rose(arst_n_in) |->
    {ch1_gain_out, ch2_gain_out, ch3_gain_out, ch4_gain_out} == {4{8'hcf}})
    else $error("gain not at reset value");
  a_line_reset: assert property ($rose(arst_n_in) |->
    !line_out_check_en_out && line_found_out == 4'h0)
    else $error("line detection not off after reset");
  a_start_state: assert property (chan_state_in[7:6] == 2'h3 &&
    $past(chan_state_in[7:6]) != 2'h3 && load_check_mask_out == 4'h0 |->
    ##[1:3] load_check_mask_out[0])
    else $error("state code did not start a run");
endmodule
bind vld_volume_diag_regs vld_volume_diag_regs_checker chk_u (.ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in), .chan_state_in(chan_state_in), .ch1_gain_out(ch1_gain_out),
  .ch2_gain_out(ch2_gain_out), .ch3_gain_out(ch3_gain_out), .ch4_gain_out(ch4_gain_out),
  .mute_out(mute_out), .load_check_mask_out(load_check_mask_out),
  .ramp_active_out(ramp_active_out), .settle_active_out(settle_active_out),
  .line_out_check_en_out(line_out_check_en_out), .line_found_out(line_found_out));

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  import vld_pkg::*;
  logic ref_clk_in;
  logic arst_n_in;
  logic scl;
  logic sda_low;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  logic [7:0] chan_state;
  logic [3:0] chan_fault;
  logic [3:0] gnd_sh;
  logic [3:0] sup_sh;
  logic [3:0] open;
  logic [3:0] line;
  logic [15:0] res;
  logic [7:0] g1;
  logic [7:0] g2;
  logic [7:0] g3;
  logic [7:0] g4;
  logic [3:0] mute;
  logic [3:0] mask;
  logic ramp;
  logic settle;
  logic line_en;
  logic [3:0] line_found;
  logic [7:0] rd;
  logic nak;
  int err_total;
  int compares;
  logic [7:0] rst_tab [9] = '{8'hcf, 8'hcf, 8'hcf, 8'hcf, 8'h00, 8'h11, 8'h11, 8'h00, 8'h00};
  logic [7:0] gain_tab [4] = '{8'h06, 8'h07, 8'hff, 8'h00};
  // Pull-up on the data line: low only while some party pulls it
  assign sda = !(sda_low || (!sda_oe_n && !sda_out));
  vld_volume_diag_regs dut_u (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .chan_state_in(chan_state),
    .chan_fault_in(chan_fault), .meas_gnd_short_in(gnd_sh), .meas_sup_short_in(sup_sh),
    .meas_open_in(open),
    .meas_line_in(line), .meas_res_in(res), .ch1_gain_out(g1), .ch2_gain_out(g2),
    .ch3_gain_out(g3), .ch4_gain_out(g4), .mute_out(mute), .load_check_mask_out(mask),
    .ramp_active_out(ramp), .settle_active_out(settle), .line_out_check_en_out(line_en),
    .line_found_out(line_found));
  vld_i2c_host hst_u (.clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hst_u.write_reg(a, d, nak);
    `CHK("write ack", 1'b0, nak)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    hst_u.read_reg(a, rd, nak);
    `CHK("read ack", 1'b0, nak)
    `CHK($sformatf("reg %h", a), e, rd)
  endtask
  task automatic tick(inout logic [11:0] n);
    @(posedge ref_clk_in);
    #1;
    n++;
  endtask
  task automatic give_up();
    err_total++;
    summarize();
  endtask
  task automatic run_check(input logic [11:0] er, input logic [11:0] es);
    logic [11:0] n;
    n = 12'h000;
    while (ramp !== 1'b1 && n < 12'h064) tick(n);
    if (n >= 12'h064) give_up();
    n = 12'h000;
    while (ramp === 1'b1 && n < 12'hbb8) tick(n);
    if (n >= 12'hbb8) give_up();
    `CHK("ramp cycles", er, n)
    n = 12'h000;
    while (settle === 1'b1 && n < 12'hbb8) tick(n);
    if (n >= 12'hbb8) give_up();
    `CHK("settle cycles", es, n)
    n = 12'h000;
    while (mask !== 4'h0 && n < 12'h00a) tick(n);
    if (n >= 12'h00a) give_up();
  endtask
  initial begin
    err_total = 0;
    compares = 0;
    arst_n_in = 1'b0;
    chan_state = 8'h55;
    chan_fault = 4'h0;
    gnd_sh = 4'h5;
    sup_sh = 4'ha;
    open = 4'h3;
    line = 4'h1;
    res = 16'h2459;
    repeat (8) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    `CHK("mute", 4'h0, mute)
    for (int i = 0; i < 9; i++) begin
      rchk(8'h05 + 8'(i), rst_tab[i]);
    end
    for (int i = 0; i < 4; i++) wr(8'h05 + 8'(i), gain_tab[i]);
    for (int i = 0; i < 4; i++) rchk(8'h05 + 8'(i), gain_tab[i]);
    `CHK("gain pins", 32'h0607ff00, {g1, g2, g3, g4})
    `CHK("mute", 4'h9, mute)
    wr(ADDR_LOAD_CTRL, 8'hff);
    rchk(ADDR_LOAD_CTRL, 8'h63);
    `CHK("line enable", 1'b1, line_en)
    chan_state = 8'h00;
    repeat (20) @(posedge ref_clk_in);
    #1;
    `CHK("mask with skip", 4'h0, mask)
    chan_state = 8'h55;
    wr(ADDR_THR_CH12, 8'h93);
    wr(ADDR_THR_CH34, 8'h58);
    rchk(ADDR_THR_CH12, 8'h93);
    rchk(ADDR_THR_CH34, 8'h58);
    wr(ADDR_REPORT_CH12, 8'hff);
    rchk(ADDR_REPORT_CH12, 8'h00);
    rchk(8'h20, 8'h00);
    wr(ADDR_LOAD_CTRL, 8'h00);
    chan_state = 8'hff;
    run_check(12'h3e8, 12'h1f4);
    rchk(ADDR_REPORT_CH12, 8'hb6);
    rchk(ADDR_REPORT_CH34, 8'h94);
    `CHK("line found", 4'h0, line_found)
    chan_state = 8'h55;
    wr(ADDR_LOAD_CTRL, 8'h62);
    chan_state = 8'hff;
    run_check(12'h7d0, 12'h3e8);
    rchk(ADDR_REPORT_CH12, 8'h96);
    `CHK("line found", 4'h1, line_found)
    wr(ADDR_LOAD_CTRL, 8'h40);
    gnd_sh = 4'h0;
    chan_fault = 4'h1;
    repeat (5) @(posedge ref_clk_in);
    #1;
    `CHK("fault run mask", 4'h1, mask)
    wr(ADDR_LOAD_CTRL, 8'hc0);
    `CHK("mask after cancel", 4'h0, mask)
    `CHK("ramp after cancel", 1'b0, ramp)
    rchk(ADDR_LOAD_CTRL, 8'h40);
    rchk(ADDR_REPORT_CH12, 8'h96);
    chan_state = 8'h55;
    repeat (4) @(posedge ref_clk_in);
    #1 chan_state = 8'h15;
    repeat (5) @(posedge ref_clk_in);
    #1;
    `CHK("hiz exit run mask", 4'h1, mask)
    summarize();
  end
endmodule
